//--- logic/sbg_defs.svh
// Constants for the serial baud-rate generator: mode codes, divider counts
// and reset values. Included by the package and by the baud-rate generator module.
`ifndef SBG_DEFS_SVH
`define SBG_DEFS_SVH

// Oscillator divide counts
`define SBG_DIV_SHIFT      12
`define SBG_DIV_STATE      2
`define SBG_DIV_MACHINE    12
`define SBG_DIV_FIXED9     64
`define SBG_DIV_FIXED9_DBL 32
`define SBG_DIV_T1_OVF     32
`define SBG_DIV_T1_OVF_DBL 16
`define SBG_DIV_T2_OVF     16
// Timer 1 mode field codes (upper nibble low bits of timer_mode_reg)
`define SBG_T1_MODE_13BIT  2'h0
`define SBG_T1_MODE_16BIT  2'h1
`define SBG_T1_MODE_AUTO8  2'h2
`define SBG_T1_MODE_SPLIT  2'h3
// Reset values
`define SBG_RST_DOUBLE     1'h0
`define SBG_RST_T2_COUNT   16'h0000

`endif

//--- logic/sbg_pkg.sv
// Types shared by the baud-rate generator modules.
// Assumes sbg_defs.svh sits in the include path.
`include "sbg_defs.svh"

package sbg_pkg;

    // Serial port operating modes
    typedef enum logic [1:0]
    {
        SBG_MODE_SHIFT  = 2'b00,
        SBG_MODE_VAR8   = 2'b01,
        SBG_MODE_FIXED9 = 2'b10,
        SBG_MODE_VAR9   = 2'b11
    } sbg_mode_e;

endpackage

//--- logic/sbg_tick_div.sv
// Divider that turns a one-cycle input enable into a slower enable pulse.
// Assumes tick_i comes from logic on clk_sys_i; div_i may change mid-group.
`timescale 1ns/1ps

module sbg_tick_div
#(
    parameter int WIDTH = 7
)
(
    // Clock and reset
    input  wire logic             clk_sys_i,
    input  wire logic             rst_b_i,
    // Control
    input  wire logic             clr_i,
    input  wire logic [WIDTH-1:0] div_i,
    input  wire logic             tick_i,
    // Result
    output logic                  tick_o
);

    logic [WIDTH-1:0] count;

    // Refuse widths too narrow to count a group of ticks
    if (WIDTH < 2)
    begin
        $error("sbg_tick_div: WIDTH below 2");
    end

    // Counts input ticks; pulses on the last of each group of div_i
    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_b_i || clr_i)
        begin
            count  <= '0;
            tick_o <= 1'b0;
        end
        else if (tick_i)
        begin
            // At-or-past test: a smaller div_i mid-group cannot strand count
            if (count >= div_i - WIDTH'(1))
            begin
                count  <= '0;
                tick_o <= 1'b1;
            end
            else
            begin
                count  <= count + WIDTH'(1);
                tick_o <= 1'b0;
            end
        end
        else
        begin
            tick_o <= 1'b0;
        end
    end

endmodule

//--- logic/sbg_baud_gen.sv
// Serial baud-rate generator: oscillator prescaler, timer 1 and timer 2
// counters, and the per-direction bit-rate enables for the shifters.
// Assumes one oscillator clock; control bits come from register logic on
// the same clock and are plain ports; pins pass two flip-flops here.
//
// Overview of operation
// - Shift mode runs at oscillator over twelve, ignoring timers and doubling.
// - Fixed 9-bit mode runs at osc/64, or osc/32 when doubled; doubling resets clear.
// - Variable modes take the rate from timer 1, timer 2, or one each.
// - Timer 1 source: overflow rate over 32, times two when doubled.
// - Timer 1 auto-reload: rate is 2^d*osc/(32*12*(256-reload)).
// - Timer 1 serves as source in timer or counter use, any running mode.
// - Tx and rx select bits put timer 2 in generator mode per direction.
// - In generator mode a high-byte rollover reloads the full 16-bit count.
// - Timer 2 source: overflow rate over sixteen.
// - Generator timer use counts every state time, osc/2, not osc/12.
// - Generator rate is osc/(32*(65536-reload pair)).
// - Count-source select zero means timer use, one means counting pin edges.
// - Generator rollover sets no overflow flag and raises no interrupt.
// - Ext enable: falling ext pin edge sets ext flag but never reloads.
`timescale 1ns/1ps
`include "sbg_defs.svh"

module sbg_baud_gen
    import sbg_pkg::*;
(
    // Clock and reset
    input  wire logic        clk_sys_i,
    input  wire logic        rst_b_i,
    // Serial mode and doubling
    input  wire logic [1:0]  serial_mode_i,
    input  wire logic        rate_double_bit_i,
    input  wire logic        rate_double_wr_i,
    // Timer 1 configuration (timer_mode_reg upper nibble)
    input  wire logic        timer1_run_i,
    input  wire logic        timer1_gate_i,
    input  wire logic        timer1_count_source_sel_i,
    input  wire logic [1:0]  timer1_mode_i,
    input  wire logic [7:0]  timer1_upper_byte_i,
    input  wire logic        timer1_load_i,
    input  wire logic [7:0]  timer1_lower_load_i,
    // Timer 2 configuration (timer2_control_reg bits)
    input  wire logic        tx_rate_from_timer2_i,
    input  wire logic        rx_rate_from_timer2_i,
    input  wire logic        timer2_run_bit_i,
    input  wire logic        timer2_count_source_sel_i,
    input  wire logic        timer2_ext_input_enable_i,
    input  wire logic [7:0]  timer2_reload_upper_i,
    input  wire logic [7:0]  timer2_reload_lower_i,
    input  wire logic        timer2_ext_flag_clr_i,
    // Pins
    input  wire logic        timer1_pin_i,
    input  wire logic        timer1_gate_pin_i,
    input  wire logic        timer2_pin_i,
    input  wire logic        timer2_ext_pin_i,
    // Rate enables and status
    output logic             tx_bit_tick_o,
    output logic             rx_bit_tick_o,
    output logic             rate_double_o,
    output logic             timer1_overflow_o,
    output logic             timer2_overflow_flag_o,
    output logic             timer2_ext_flag_o,
    output logic [7:0]       timer2_count_upper_o,
    output logic [7:0]       timer2_count_lower_o
);

    sbg_mode_e   mode;
    logic [3:0]  osc_cnt;
    logic        state_tick;
    logic        mach_tick;
    logic        fix_tick;
    logic [5:0]  fix_cnt;
    logic [2:0]  t1_s1, t1_s2, t2_s1, t2_s2;
    logic        t1_q, t2_q, timer2_ext_pin_q;
    logic        t1_fall, t2_fall, timer2_ext_pin_fall;
    logic [7:0]  t1_lo, t1_hi;
    logic        t1_inc, t1_ovf;
    logic [15:0] t2_cnt;
    logic        t2_gen, t2_inc, t2_ovf;
    logic        t1_div_tick, t2_div_tick;
    logic [6:0]  t1_div;
    logic        next_tx, next_rx;

    assign mode = sbg_mode_e'(serial_mode_i);
    assign t2_gen = tx_rate_from_timer2_i | rx_rate_from_timer2_i;

    // Pin synchronisers; the first stage feeds only the second
    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_b_i)
        begin
            t1_s1 <= 3'h7;
            t1_s2 <= 3'h7;
        end
        else
        begin
            t1_s1 <= {timer1_pin_i, timer1_gate_pin_i, timer2_pin_i};
            t1_s2 <= t1_s1;
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_b_i)
        begin
            t2_s1  <= 3'h7;
            t2_s2  <= 3'h7;
            t1_q   <= 1'b1;
            t2_q   <= 1'b1;
            timer2_ext_pin_q <= 1'b1;
        end
        else
        begin
            t2_s1  <= {timer2_ext_pin_i, 2'h3};
            t2_s2  <= t2_s1;
            t1_q   <= t1_s2[2];
            t2_q   <= t1_s2[0];
            timer2_ext_pin_q <= t2_s2[2];
        end
    end

    // Falling edges, seen after synchronising
    assign t1_fall   = t1_q & ~t1_s2[2];
    assign t2_fall   = t2_q & ~t1_s2[0];
    assign timer2_ext_pin_fall = timer2_ext_pin_q & ~t2_s2[2];

    // Oscillator prescaler: state time every 2, machine cycle every 12
    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_b_i)
            osc_cnt <= 4'h0;
        else if (osc_cnt == 4'(`SBG_DIV_MACHINE - 1))
            osc_cnt <= 4'h0;
        else
            osc_cnt <= osc_cnt + 4'h1;
    end

    assign state_tick = osc_cnt[0];
    assign mach_tick  = (osc_cnt == 4'(`SBG_DIV_MACHINE - 1));

    // Doubling bit, cleared by reset
    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_b_i)
            rate_double_o <= `SBG_RST_DOUBLE;
        else if (rate_double_wr_i)
            rate_double_o <= rate_double_bit_i;
    end

    // Fixed 9-bit rate counter: terminal at 64 or 32 oscillator periods
    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_b_i)
            fix_cnt <= 6'h00;
        else
            fix_cnt <= fix_cnt + 6'h01;
    end

    assign fix_tick = rate_double_o ? (fix_cnt[4:0] == 5'h1F)
                                    : (fix_cnt == 6'h3F);

    // Timer 1: timer or counter use in any counting mode
    assign t1_inc = timer1_run_i & (~timer1_gate_i | t1_s2[1]) &
                    (timer1_count_source_sel_i ? t1_fall : mach_tick);
    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_b_i)
        begin
            t1_lo <= 8'h00;
            t1_hi <= 8'h00;
        end
        else if (timer1_load_i)
        begin
            t1_lo <= timer1_lower_load_i;   // software reload, low-rate use
            t1_hi <= timer1_upper_byte_i;
        end
        else if (t1_inc)
        begin
            unique case (timer1_mode_i)
                `SBG_T1_MODE_13BIT:
                begin
                    t1_lo <= {3'h0, t1_lo[4:0] + 5'h01};
                    if (t1_lo[4:0] == 5'h1F)
                        t1_hi <= t1_hi + 8'h01;
                end
                `SBG_T1_MODE_16BIT:
                begin
                    t1_lo <= t1_lo + 8'h01;
                    if (t1_lo == 8'hFF)
                        t1_hi <= t1_hi + 8'h01;
                end
                `SBG_T1_MODE_AUTO8:
                    t1_lo <= (t1_lo == 8'hFF) ? timer1_upper_byte_i
                                              : t1_lo + 8'h01;
                `SBG_T1_MODE_SPLIT:
                    t1_hi <= t1_hi;       // Halted, holds its count
            endcase
        end
    end

    always_comb
    begin
        unique case (timer1_mode_i)
            `SBG_T1_MODE_13BIT:
                t1_ovf = t1_inc & (t1_lo[4:0] == 5'h1F) & (t1_hi == 8'hFF);
            `SBG_T1_MODE_16BIT:
                t1_ovf = t1_inc & (t1_lo == 8'hFF) & (t1_hi == 8'hFF);
            `SBG_T1_MODE_AUTO8:
                t1_ovf = t1_inc & (t1_lo == 8'hFF);
            `SBG_T1_MODE_SPLIT:
                t1_ovf = 1'b0;
        endcase
    end

    // Timer 2 in generator mode: state-time or pin counting, auto reload
    assign t2_inc = timer2_run_bit_i &
                    (timer2_count_source_sel_i ? t2_fall : state_tick);
    assign t2_ovf = t2_gen & t2_inc & (t2_cnt == 16'hFFFF);

    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_b_i)
            t2_cnt <= `SBG_RST_T2_COUNT;
        // A stopped timer presets from the reload pair: there is no
        // count write path, and a start from zero would take 2^17 cycles
        else if (!timer2_run_bit_i)
            t2_cnt <= {timer2_reload_upper_i, timer2_reload_lower_i};
        else if (t2_gen && t2_inc)
        begin
            if (t2_cnt == 16'hFFFF)
                t2_cnt <= {timer2_reload_upper_i, timer2_reload_lower_i};
            else
                t2_cnt <= t2_cnt + 16'h0001;
        end
    end

    // Flags: rollover in generator mode never sets the overflow flag;
    // pin edge sets the ext flag only, and a set beats a clear
    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_b_i)
        begin
            timer2_overflow_flag_o <= 1'b0;
            timer2_ext_flag_o      <= 1'b0;
        end
        else
        begin
            timer2_overflow_flag_o <= 1'b0;
            if (t2_gen && timer2_ext_input_enable_i && timer2_ext_pin_fall)
                timer2_ext_flag_o <= 1'b1;
            else if (timer2_ext_flag_clr_i)
                timer2_ext_flag_o <= 1'b0;
        end
    end

    // Overflow dividers: timer 1 by 32 (16 doubled), timer 2 by 16
    assign t1_div = rate_double_o ? 7'(`SBG_DIV_T1_OVF_DBL)
                                  : 7'(`SBG_DIV_T1_OVF);

    sbg_tick_div #(.WIDTH(7)) u_t1_div
    (
        .clk_sys_i (clk_sys_i),
        .rst_b_i   (rst_b_i),
        .clr_i     (1'b0),
        .div_i     (t1_div),
        .tick_i    (t1_ovf),
        .tick_o    (t1_div_tick)
    );

    sbg_tick_div #(.WIDTH(7)) u_t2_div
    (
        .clk_sys_i (clk_sys_i),
        .rst_b_i   (rst_b_i),
        .clr_i     (~t2_gen),
        .div_i     (7'(`SBG_DIV_T2_OVF)),
        .tick_i    (t2_ovf),
        .tick_o    (t2_div_tick)
    );

    // Rate selection per direction
    always_comb
    begin
        unique case (mode)
            SBG_MODE_SHIFT:
            begin
                next_tx = mach_tick;
                next_rx = mach_tick;
            end
            SBG_MODE_FIXED9:
            begin
                next_tx = fix_tick;
                next_rx = fix_tick;
            end
            SBG_MODE_VAR8, SBG_MODE_VAR9:
            begin
                next_tx = tx_rate_from_timer2_i ? t2_div_tick
                                                : t1_div_tick;
                next_rx = rx_rate_from_timer2_i ? t2_div_tick
                                                : t1_div_tick;
            end
        endcase
    end

    // Registered outputs
    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_b_i)
        begin
            tx_bit_tick_o        <= 1'b0;
            rx_bit_tick_o        <= 1'b0;
            timer1_overflow_o    <= 1'b0;
            timer2_count_upper_o <= 8'h00;
            timer2_count_lower_o <= 8'h00;
        end
        else
        begin
            tx_bit_tick_o        <= next_tx;
            rx_bit_tick_o        <= next_rx;
            timer1_overflow_o    <= t1_ovf;
            timer2_count_upper_o <= t2_cnt[15:8];
            timer2_count_lower_o <= t2_cnt[7:0];
        end
    end

    // Checks
    sequence s_shift_tick;
        mach_tick ##1 tx_bit_tick_o;
    endsequence

    a_shift_rate_fixed: assert property (@(posedge clk_sys_i)
        disable iff (!rst_b_i)
        (mode == SBG_MODE_SHIFT && $stable(mode)) ##0 s_shift_tick
        |-> ##12 (tx_bit_tick_o || $past(mode) != SBG_MODE_SHIFT))
        else $error("shift mode tick spacing wrong");
    a_double_reset: assert property (@(posedge clk_sys_i)
        !rst_b_i |=> !rate_double_o)
        else $error("doubling bit not cleared by reset");
    a_gen_no_ovf_flag: assert property (@(posedge clk_sys_i)
        disable iff (!rst_b_i)
        t2_ovf |=> !timer2_overflow_flag_o)
        else $error("generator rollover set overflow flag");
    a_t2_reload_value: assert property (@(posedge clk_sys_i)
        disable iff (!rst_b_i)
        t2_ovf |=> t2_cnt == $past({timer2_reload_upper_i,
                                    timer2_reload_lower_i}))
        else $error("timer 2 reload value wrong");
    a_ext_sets_flag: assert property (@(posedge clk_sys_i)
        disable iff (!rst_b_i)
        (t2_gen && timer2_ext_input_enable_i && timer2_ext_pin_fall)
        |=> timer2_ext_flag_o)
        else $error("ext flag not set by pin edge");
    a_ext_no_reload: assert property (@(posedge clk_sys_i)
        disable iff (!rst_b_i)
        (timer2_ext_pin_fall && !t2_inc && timer2_run_bit_i) |=> $stable(t2_cnt))
        else $error("ext edge disturbed timer 2 count");
    a_state_time_inc: assert property (@(posedge clk_sys_i)
        disable iff (!rst_b_i)
        (t2_gen && timer2_run_bit_i && !timer2_count_source_sel_i &&
         t2_cnt != 16'hFFFF && state_tick) |=> t2_cnt == $past(t2_cnt) + 1)
        else $error("timer 2 did not count state time");
    a_tx_source_t2: assert property (@(posedge clk_sys_i)
        disable iff (!rst_b_i)
        ((mode == SBG_MODE_VAR8 || mode == SBG_MODE_VAR9) &&
         tx_rate_from_timer2_i && !t2_div_tick)
        |=> !tx_bit_tick_o)
        else $error("tx tick without timer 2 source");
    a_rx_source_t1: assert property (@(posedge clk_sys_i)
        disable iff (!rst_b_i)
        (mode == SBG_MODE_VAR9 && !rx_rate_from_timer2_i)
        |=> rx_bit_tick_o == $past(t1_div_tick))
        else $error("rx tick not from timer 1");

endmodule

//--- verif/sbg_shift_model.sv
// Stand-in for the serial shifters: counts bit-rate enables per direction
// and measures the cycles between the last two of each.
// Assumes tick inputs are one-cycle pulses on clk_sys_i.
`timescale 1ns/1ps

module sbg_shift_model
(
    // Clock and reset
    input  wire logic        clk_sys_i,
    input  wire logic        rst_b_i,
    // Rate enables from the generator
    input  wire logic        tx_bit_tick_i,
    input  wire logic        rx_bit_tick_i,
    // Measurements
    output logic [15:0]      tx_period_o,
    output logic [15:0]      rx_period_o,
    output logic [15:0]      tx_count_o,
    output logic [15:0]      rx_count_o
);
    logic [15:0] tx_age;
    logic [15:0] rx_age;

    // Transmit side: a shifter only sees one bit slot per enable
    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_b_i)
        begin
            tx_age      <= 16'h0001;
            tx_period_o <= 16'h0000;
            tx_count_o  <= 16'h0000;
        end
        else if (tx_bit_tick_i)
        begin
            tx_period_o <= tx_age;
            tx_age      <= 16'h0001;
            tx_count_o  <= tx_count_o + 16'h0001;
        end
        else
            tx_age <= tx_age + 16'h0001;
    end

    // Receive side, kept apart since the two rates may differ
    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_b_i)
        begin
            rx_age      <= 16'h0001;
            rx_period_o <= 16'h0000;
            rx_count_o  <= 16'h0000;
        end
        else if (rx_bit_tick_i)
        begin
            rx_period_o <= rx_age;
            rx_age      <= 16'h0001;
            rx_count_o  <= rx_count_o + 16'h0001;
        end
        else
            rx_age <= rx_age + 16'h0001;
    end
endmodule

//--- verif/sbg_baud_gen_tb.sv
// Self-checking bench for the baud-rate generator: sets each rate source
// and compares the measured enable periods with figures from the formulas.
// Assumes the design package and defines header are compiled first.
`timescale 1ns/1ps

`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin \
    bad_count++; $display("[FAIL] %s expected %0h seen %0h", nm, e, g); \
    end end

module sbg_baud_gen_tb;
    import sbg_pkg::*;

    logic        clk_sys_i = 1'b0;
    logic        rst_b_i = 1'b0;
    logic [1:0]  mode = SBG_MODE_SHIFT;
    logic        dbl = 1'b0, dbl_wr = 1'b0;
    logic        t1_run = 1'b0, t1_gate = 1'b0, t1_src = 1'b0;
    logic [1:0]  t1_mode = 2'h2;
    logic [7:0]  t1_hi = 8'hFF, t1_lo = 8'hFF;
    logic        t1_load = 1'b0, tx_t2 = 1'b0, rx_t2 = 1'b0;
    logic        t2_run = 1'b0, t2_src = 1'b0, t2_ext_en = 1'b0;
    logic [7:0]  rl_hi = 8'hFF, rl_lo = 8'hFE;
    logic        ext_clr = 1'b0, gate_pin = 1'b0, ext_pin = 1'b1;
    logic        pin_wave = 1'b1, pin_on = 1'b0;
    logic [1:0]  pin_cnt = 2'h0;
    logic        tx_tick, rx_tick, dbl_o, t1_ovf, t2_ovf, ext_flag;
    logic [7:0]  cnt_hi, cnt_lo;
    logic [15:0] tx_per, rx_per, tx_cnt, rx_cnt;
    logic        sw_on = 1'b0, sw_load = 1'b0;
    logic [15:0] c0 = 16'h0000;
    int          o0 = 0;
    int          t1_ovf_n = 0;
    int          bad_count = 0;
    int          num_checks = 0;

    // 25 MHz oscillator
    always #20 clk_sys_i = ~clk_sys_i;

    // Pin wave with a falling edge every 8 cycles while enabled
    always @(posedge clk_sys_i)
    begin
        if (pin_on)
        begin
            pin_cnt <= pin_cnt + 2'h1;
            if (pin_cnt == 2'h3)
                pin_wave <= ~pin_wave;
        end
    end

    // Software stand-in: counts timer 1 overflows and, when on, reloads
    // the count one cycle after each, as an interrupt handler would
    always @(posedge clk_sys_i)
    begin
        sw_load <= sw_on & t1_ovf;
        if (t1_ovf)
            t1_ovf_n <= t1_ovf_n + 1;
    end

    sbg_baud_gen i_dut (
        .clk_sys_i                 (clk_sys_i),
        .rst_b_i                   (rst_b_i),
        .serial_mode_i             (mode),
        .rate_double_bit_i         (dbl),
        .rate_double_wr_i          (dbl_wr),
        .timer1_run_i              (t1_run),
        .timer1_gate_i             (t1_gate),
        .timer1_count_source_sel_i (t1_src),
        .timer1_mode_i             (t1_mode),
        .timer1_upper_byte_i       (t1_hi),
        .timer1_load_i             (t1_load | sw_load),
        .timer1_lower_load_i       (t1_lo),
        .tx_rate_from_timer2_i     (tx_t2),
        .rx_rate_from_timer2_i     (rx_t2),
        .timer2_run_bit_i          (t2_run),
        .timer2_count_source_sel_i (t2_src),
        .timer2_ext_input_enable_i (t2_ext_en),
        .timer2_reload_upper_i     (rl_hi),
        .timer2_reload_lower_i     (rl_lo),
        .timer2_ext_flag_clr_i     (ext_clr),
        .timer1_pin_i              (pin_wave),
        .timer1_gate_pin_i         (gate_pin),
        .timer2_pin_i              (pin_wave),
        .timer2_ext_pin_i          (ext_pin),
        .tx_bit_tick_o             (tx_tick),
        .rx_bit_tick_o             (rx_tick),
        .rate_double_o             (dbl_o),
        .timer1_overflow_o         (t1_ovf),
        .timer2_overflow_flag_o    (t2_ovf),
        .timer2_ext_flag_o         (ext_flag),
        .timer2_count_upper_o      (cnt_hi),
        .timer2_count_lower_o      (cnt_lo)
    );

    sbg_shift_model i_shift (
        .clk_sys_i     (clk_sys_i),
        .rst_b_i       (rst_b_i),
        .tx_bit_tick_i (tx_tick),
        .rx_bit_tick_i (rx_tick),
        .tx_period_o   (tx_per),
        .rx_period_o   (rx_per),
        .tx_count_o    (tx_cnt),
        .rx_count_o    (rx_cnt)
    );

    // Verdict and end of run, also reached by a spent wait
    task automatic close_out();
        $display("Checks %0d, mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // Write the doubling bit with a one-cycle strobe
    task automatic set_double(input logic v);
        @(posedge clk_sys_i);
        dbl    <= v;
        dbl_wr <= 1'b1;
        @(posedge clk_sys_i);
        dbl_wr <= 1'b0;
    endtask

    // Let four enables pass per side so the first ragged interval is gone
    task automatic meas(input string nm, input logic [15:0] etx,
                        input logic [15:0] erx);
        logic [15:0] t0;
        logic [15:0] r0;
        int          n;
        t0 = tx_cnt;
        r0 = rx_cnt;
        n  = 0;
        while ((tx_cnt - t0 < 16'h0004 || rx_cnt - r0 < 16'h0004)
               && n < 8000)
        begin
            @(posedge clk_sys_i);
            n++;
        end
        if (n >= 8000)
        begin
            bad_count++;
            $display("[FAIL] %s expected ticks seen none", nm);
            close_out();
        end
        #1;
        `CHK({nm, " tx period"}, etx, tx_per)
        `CHK({nm, " rx period"}, erx, rx_per)
        $display("Test %s done", nm);
        @(posedge clk_sys_i);
    endtask

    // Main sequence
    initial
    begin
        repeat (4) @(posedge clk_sys_i);
        rst_b_i <= 1'b1;
        #1;
        `CHK("double after reset", 1'h0, dbl_o)
        set_double(1'b1);
        #1;
        `CHK("double written", 1'h1, dbl_o)
        meas("shift", 16'h000C, 16'h000C);
        set_double(1'b0);
        mode <= SBG_MODE_FIXED9;
        meas("fixed9", 16'h0040, 16'h0040);
        set_double(1'b1);
        meas("fixed9 dbl", 16'h0020, 16'h0020);
        // Timer 1 auto-reload from 0xFF: one overflow per machine cycle
        set_double(1'b0);
        mode    <= SBG_MODE_VAR8;
        t1_load <= 1'b1;
        @(posedge clk_sys_i);
        t1_load <= 1'b0;
        t1_run  <= 1'b1;
        meas("t1 timer", 16'h0180, 16'h0180);
        #1;
        o0 = t1_ovf_n;
        repeat (120) @(posedge clk_sys_i);
        #1;
        `CHK("t1 overflows", o0 + 10, t1_ovf_n)
        set_double(1'b1);
        meas("t1 timer dbl", 16'h00C0, 16'h00C0);
        set_double(1'b0);
        t1_src <= 1'b1;
        pin_on <= 1'b1;
        meas("t1 counter", 16'h0100, 16'h0100);
        // Gate held low stops timer 1, so no enables at all
        t1_gate <= 1'b1;
        repeat (300) @(posedge clk_sys_i);
        repeat (900) @(posedge clk_sys_i);
        `CHK("gated stall", rx_cnt, tx_cnt)
        c0 = tx_cnt;
        o0 = t1_ovf_n;
        repeat (800) @(posedge clk_sys_i);
        #1;
        `CHK("gated count", c0, tx_cnt)
        `CHK("gated overflows", o0, t1_ovf_n)
        @(posedge clk_sys_i);
        gate_pin <= 1'b1;
        meas("t1 gate open", 16'h0100, 16'h0100);
        // 16-bit and 13-bit use, reloaded by software on each overflow
        t1_src  <= 1'b0;
        t1_gate <= 1'b0;
        t1_mode <= 2'h1;
        t1_lo   <= 8'hFE;
        t1_load <= 1'b1;
        sw_on   <= 1'b1;
        @(posedge clk_sys_i);
        t1_load <= 1'b0;
        meas("t1 16-bit", 16'h0300, 16'h0300);
        t1_mode <= 2'h0;
        t1_lo   <= 8'hFF;
        t1_load <= 1'b1;
        @(posedge clk_sys_i);
        t1_load <= 1'b0;
        meas("t1 13-bit", 16'h0180, 16'h0180);
        // Mode 3 halts timer 1, so no overflow follows
        sw_on   <= 1'b0;
        t1_mode <= 2'h3;
        repeat (4) @(posedge clk_sys_i);
        #1;
        o0 = t1_ovf_n;
        repeat (400) @(posedge clk_sys_i);
        #1;
        `CHK("t1 halted", o0, t1_ovf_n)
        @(posedge clk_sys_i);
        t1_mode <= 2'h2;
        t1_load <= 1'b1;
        @(posedge clk_sys_i);
        t1_load <= 1'b0;
        // Timer 2 stopped while its reload stays put, then started
        mode   <= SBG_MODE_VAR9;
        rl_lo  <= 8'hFE;
        tx_t2  <= 1'b1;
        t2_run <= 1'b1;
        meas("t2 tx", 16'h0040, 16'h0180);
        tx_t2 <= 1'b0;
        rx_t2 <= 1'b1;
        meas("t2 rx", 16'h0180, 16'h0040);
        tx_t2 <= 1'b1;
        meas("t2 both", 16'h0040, 16'h0040);
        #1;
        `CHK("t2 overflow flag", 1'h0, t2_ovf)
        `CHK("t2 count upper", 8'hFF, cnt_hi)
        @(posedge clk_sys_i);
        // Falling ext pin raises the flag but leaves the rate alone
        t2_ext_en <= 1'b1;
        ext_pin   <= 1'b0;
        repeat (6) @(posedge clk_sys_i);
        #1;
        `CHK("ext flag set", 1'h1, ext_flag)
        meas("t2 after ext", 16'h0040, 16'h0040);
        ext_clr <= 1'b1;
        @(posedge clk_sys_i);
        ext_clr <= 1'b0;
        @(posedge clk_sys_i);
        #1;
        `CHK("ext flag clear", 1'h0, ext_flag)
        // Counter use: one increment per falling pin edge
        @(posedge clk_sys_i);
        t2_run <= 1'b0;
        @(posedge clk_sys_i);
        rl_lo  <= 8'hFF;
        t2_src <= 1'b1;
        @(posedge clk_sys_i);
        t2_run <= 1'b1;
        meas("t2 counter", 16'h0080, 16'h0080);
        #1;
        `CHK("t2 overflow flag", 1'h0, t2_ovf)
        `CHK("t2 count lower", 8'hFF, cnt_lo)
        close_out();
    end
endmodule
